// *** rtl/rsp_stack.sv ***
// Return address stack, fast register shadow and PC holding latches
//
// Design decisions made here: the Wishbone interface to the registers and the register addresses.
`include "rsp_cfg.svh"

//Contract
// - Pointer spans 0..31, steps one per push/pop
// - Every reset clears the stack pointer
// - Software reads and writes the stack pointer
// - Full flag sets on 31st unpopped push
// - Fault reset on: store PC+2, reset, pointer zero
// - Fault reset off: pointer sticks at 31
// - Empty pop sets underflow; returns also load zero PC
// - Fault enable decides flag-only or reset
// - Flags cleared only by software or power-on
// - Status layout: full, underflow, zero, pointer
// - Push instruction increments then stores PC
// - Pop instruction discards top by decrementing
// - Shadow captures status, W, bank on vector
// - Shadow has no software access
// - Fast return restores shadow; normal return not
// - High interrupt overwrites low interrupt shadow
// - Fast call loads the shadow store
// - PC 21 bits; only low byte accessible
// - PC bit zero fixed, advance by two; returns copy bit zero of the top entry, which software can set
// - Calls, jumps, branches load PC directly
// - Low byte write loads both latches into PC
// - Low byte read copies PC into latches
// - Calls and interrupts push; returns pop
// - Push increments then writes; pop reads then decrements
// - Top entry bytes readable and writable
module rsp_stack #(
	parameter int STACK_LEVELS = 31
) (
	input  wire logic                 clk_i,
	input  wire logic                 rst_i,
	input  wire logic                 dev_rst_i,
	input  wire rsp_pkg::rsp_core_s   core_i,
	input  wire logic                 cyc_i,
	input  wire logic                 stb_i,
	input  wire logic                 we_i,
	input  wire logic [7:0]           adr_i,
	input  wire logic [3:0]           sel_i,
	input  wire logic [31:0]          dat_i,
	output logic                      ack_o,
	output logic [31:0]               dat_o,
	output rsp_pkg::rsp_addr_t        pc_o,
	output rsp_pkg::rsp_restore_s     restore_o,
	output logic                      dev_reset_o
);
	import rsp_pkg::*;

	if (STACK_LEVELS != 31) begin : g_bad_levels
		$error("rsp_stack serves exactly 31 levels with a 5-bit pointer");
	end

	rsp_state_s s;
	rsp_state_s next_s;

	logic       bus_req;
	logic       bus_take;
	logic       bus_wr;
	logic       bus_rd;
	logic       sp_wr;
	logic [7:0] sp_byte;
	logic [20:0] top_val;

	assign bus_req  = cyc_i & stb_i;
	assign bus_take = bus_req & s.ack;
	assign bus_wr   = bus_take & we_i & sel_i[0];
	assign bus_rd   = bus_take & ~we_i;
	assign sp_wr    = bus_wr & (adr_i == `RSP_OFF_SP_STATUS);
	// Status layout
	// bit packing
	assign sp_byte  = {s.full, s.unf, 1'b0, s.sp};
	// No storage behind pointer zero
	assign top_val  = (s.sp == 5'h00) ? 21'h000000 : s.mem[s.sp];

	always_comb begin
		logic       do_push;
		logic       do_pop;
		logic       load_pc;
		logic       set_full;
		logic       set_unf;
		logic [4:0] up;
		do_push  = 1'b0;
		do_pop   = 1'b0;
		load_pc  = 1'b0;
		set_full = 1'b0;
		set_unf  = 1'b0;
		up       = 5'(s.sp + 5'h01);
		next_s   = s;
		next_s.restore.valid = 1'b0;
		next_s.dev_rst = 1'b0;
		next_s.ack = bus_req & ~s.ack;

		// Read data is staged so it is valid at the acknowledge edge
		if (bus_req & ~s.ack & ~we_i) begin
			case (adr_i)
				`RSP_OFF_SP_STATUS:   next_s.dat = {24'h000000, sp_byte};
				`RSP_OFF_TOP_LOW:     next_s.dat = {24'h000000, top_val[7:0]};
				`RSP_OFF_TOP_HIGH:    next_s.dat = {24'h000000, top_val[15:8]};
				`RSP_OFF_TOP_UPPER:   next_s.dat = {27'h0000000, top_val[20:16]};
				`RSP_OFF_PC_LOW:      next_s.dat = {24'h000000, s.pc[7:0]};
				`RSP_OFF_LATCH_HIGH:  next_s.dat = {24'h000000, s.lath};
				`RSP_OFF_LATCH_UPPER: next_s.dat = {27'h0000000, s.latu};
				`RSP_OFF_CONFIG:      next_s.dat = {31'h00000000, s.fault_en};
				default:              next_s.dat = 32'h00000000;
			endcase
		end else begin
			next_s.dat = 32'h00000000;
		end

		case (core_i.op)
			RSP_OP_ADVANCE: begin
				next_s.pc = 21'(s.pc + `RSP_PC_STEP);
			end
			RSP_OP_JUMP: begin
				next_s.pc = {core_i.target[20:1], 1'b0};
			end
			RSP_OP_CALL, RSP_OP_CALL_FAST, RSP_OP_INT_VEC: begin
				do_push = 1'b1;
				next_s.pc = {core_i.target[20:1], 1'b0};
			end
			RSP_OP_PUSH: begin
				do_push = 1'b1;
			end
			RSP_OP_POP: begin
				do_pop = 1'b1;
			end
			RSP_OP_RETURN, RSP_OP_RETURN_FAST: begin
				do_pop = 1'b1;
				load_pc = 1'b1;
			end
			default: begin
				do_push = 1'b0;
			end
		endcase

		// capture on vector, last vector wins
		if (core_i.op == RSP_OP_INT_VEC || core_i.op == RSP_OP_CALL_FAST) begin
			next_s.sh_status = core_i.status;
			next_s.sh_working_register   = core_i.working_register;
			next_s.sh_bsr    = core_i.bank_select_register;
		end
		if (core_i.op == RSP_OP_RETURN_FAST) begin
			next_s.restore = {1'b1, s.sh_status, s.sh_working_register, s.sh_bsr};
		end

		if (do_push) begin
			if (s.sp == `RSP_SP_LAST_FREE) begin
				set_full = 1'b1;
				if (s.fault_en) begin
					next_s.mem[`RSP_SP_TOP] = 21'(s.pc + `RSP_PC_STEP);
					next_s.sp = `RSP_SP_RST;
					next_s.dev_rst = 1'b1;
				end else begin
					next_s.mem[`RSP_SP_TOP] = s.pc;
					next_s.sp = `RSP_SP_TOP;
				end
			end else if (s.sp == `RSP_SP_TOP) begin
				set_full = 1'b1;
				next_s.dev_rst = s.fault_en;
				if (s.fault_en) begin
					next_s.sp = `RSP_SP_RST;
				end
			end else begin
				next_s.sp = up;
				next_s.mem[up] = s.pc;
			end
		end

		if (do_pop) begin
			if (s.sp == 5'h00) begin
				set_unf = 1'b1;
				next_s.dev_rst = s.fault_en;
				if (load_pc) begin
					next_s.pc = `RSP_PC_RST;
				end
			end else begin
				if (load_pc) begin
					next_s.pc = s.mem[s.sp];
				end
				next_s.sp = 5'(s.sp - 5'h01);
			end
		end

		// Bus writes come last so they win over the core
		if (bus_wr) begin
			case (adr_i)
				`RSP_OFF_SP_STATUS: begin
					next_s.sp = dat_i[`RSP_SP_MSB:`RSP_SP_LSB];
				end
				`RSP_OFF_TOP_LOW: begin
					if (s.sp != 5'h00) begin
						next_s.mem[s.sp][7:0] = dat_i[7:0];
					end
				end
				`RSP_OFF_TOP_HIGH: begin
					if (s.sp != 5'h00) begin
						next_s.mem[s.sp][15:8] = dat_i[7:0];
					end
				end
				`RSP_OFF_TOP_UPPER: begin
					if (s.sp != 5'h00) begin
						next_s.mem[s.sp][20:16] = dat_i[4:0];
					end
				end
				`RSP_OFF_PC_LOW: begin
					next_s.pc = {s.latu, s.lath, dat_i[7:1], 1'b0};
				end
				`RSP_OFF_LATCH_HIGH:  next_s.lath = dat_i[7:0];
				`RSP_OFF_LATCH_UPPER: next_s.latu = dat_i[4:0];
				`RSP_OFF_CONFIG: begin
					next_s.fault_en = dat_i[`RSP_FAULT_EN_BIT];
				end
				default: begin
					next_s.lath = s.lath;
				end
			endcase
		end
		if (bus_rd && adr_i == `RSP_OFF_PC_LOW) begin
			next_s.lath = s.pc[15:8];
			next_s.latu = s.pc[20:16];
		end

		// Writing zero clears a flag; a same-cycle set wins
		// software clear only
		next_s.full = set_full |
			(s.full & ~(sp_wr & ~dat_i[`RSP_FULL_BIT]));
		next_s.unf = set_unf |
			(s.unf & ~(sp_wr & ~dat_i[`RSP_UNF_BIT]));

		// Device reset keeps flags, config, stack RAM and shadow
		if (dev_rst_i) begin
			next_s.sp = `RSP_SP_RST;
			next_s.pc = `RSP_PC_RST;
			next_s.lath = 8'h00;
			next_s.latu = 5'h00;
			next_s.restore = '0;
			next_s.dev_rst = 1'b0;
			next_s.ack = 1'b0;
			next_s.dat = 32'h00000000;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s <= '0;
			s.fault_en <= `RSP_FAULT_EN_RST;
		end else begin
			s <= next_s;
		end
	end

	assign ack_o       = s.ack;
	assign dat_o       = s.dat;
	assign pc_o        = s.pc;
	assign restore_o   = s.restore;
	assign dev_reset_o = s.dev_rst;

	// shadow has no bus path; only restore_o reveals it

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	logic quiet;
	assign quiet = ~dev_rst_i & ~sp_wr;

	sp_reset_a: assert property (
		dev_rst_i |=> (s.sp == 5'h00))
		else $error("stack pointer not zero after reset");

	sp_step_a: assert property (
		(quiet && core_i.op == RSP_OP_CALL && s.sp < `RSP_SP_LAST_FREE)
		|=> (s.sp == 5'($past(s.sp) + 5'h01)))
		else $error("push did not step pointer by one");

	push_store_a: assert property (
		(quiet && core_i.op == RSP_OP_PUSH && s.sp < `RSP_SP_LAST_FREE
			&& !bus_wr)
		|=> (s.mem[s.sp] == $past(s.pc)))
		else $error("pushed entry does not hold the PC");

	full_reset_a: assert property (
		(quiet && s.fault_en && s.sp == `RSP_SP_LAST_FREE
			&& (core_i.op == RSP_OP_CALL || core_i.op == RSP_OP_PUSH))
		|=> (dev_reset_o && s.full && s.sp == 5'h00
			&& s.mem[`RSP_SP_TOP] == 21'($past(s.pc) + `RSP_PC_STEP)))
		else $error("31st push with fault reset misbehaved");

	full_stuck_a: assert property (
		(quiet && core_i.op == RSP_OP_PUSH && !s.fault_en
			&& s.sp == `RSP_SP_TOP && !bus_wr)
		|=> (s.sp == `RSP_SP_TOP && s.full && !dev_reset_o
			&& $stable(s.mem[`RSP_SP_TOP])))
		else $error("push beyond full moved pointer or entry");

	underflow_a: assert property (
		(quiet && core_i.op == RSP_OP_RETURN && s.sp == 5'h00
			&& !(bus_wr && adr_i == `RSP_OFF_PC_LOW))
		|=> (s.unf && s.sp == 5'h00 && pc_o == 21'h000000
			&& dev_reset_o == $past(s.fault_en)))
		else $error("empty pop did not underflow correctly");

	flags_hold_a: assert property (
		(dev_rst_i && !sp_wr)
		|=> ((s.full || !$past(s.full)) && (s.unf || !$past(s.unf))))
		else $error("device reset cleared a stack flag");

	pcl_write_a: assert property (
		(bus_wr && adr_i == `RSP_OFF_PC_LOW && !dev_rst_i)
		|=> (pc_o == {$past(s.latu), $past(s.lath),
			$past(dat_i[7:1]), 1'b0}))
		else $error("PC low write did not merge the latches");

	pcl_read_a: assert property (
		(bus_rd && adr_i == `RSP_OFF_PC_LOW && !dev_rst_i)
		|=> (s.lath == $past(s.pc[15:8]) && s.latu == $past(s.pc[20:16])))
		else $error("PC low read did not fill the latches");

	fast_ret_a: assert property (
		(!dev_rst_i && core_i.op == RSP_OP_CALL_FAST)
		##1 (core_i.op == RSP_OP_NONE)
		##1 (!dev_rst_i && core_i.op == RSP_OP_RETURN_FAST)
		|=> (restore_o.valid
			&& restore_o.working_register == $past(core_i.working_register, 3)))
		else $error("fast return did not restore the shadow");

	sw_wins_a: assert property (
		(sp_wr && !dev_rst_i && core_i.op == RSP_OP_PUSH)
		|=> (s.sp == $past(dat_i[4:0])))
		else $error("hardware push beat a software pointer write");

	pc_even_a: assert property (
		pc_o[0] == 1'b0)
		else $error("PC bit zero is set");

	ack_pulse_a: assert property (
		ack_o |=> !ack_o)
		else $error("acknowledge held longer than one cycle");

	cov_full_c: cover property (
		core_i.op == RSP_OP_PUSH && s.sp == `RSP_SP_LAST_FREE ##1 s.full);
	cov_unf_c: cover property (
		core_i.op == RSP_OP_RETURN && s.sp == 5'h00 ##1 s.unf);
	cov_fast_c: cover property (restore_o.valid);
	cov_pcl_c: cover property (bus_wr && adr_i == `RSP_OFF_PC_LOW);
endmodule

// *** common/rsp_cfg.svh ***
// Offsets, field positions, reset values and counts of the return stack block
`ifndef RSP_CFG_SVH
`define RSP_CFG_SVH

// Register byte offsets on the Wishbone slave
`define RSP_OFF_SP_STATUS   8'h00
`define RSP_OFF_TOP_LOW     8'h04
`define RSP_OFF_TOP_HIGH    8'h08
`define RSP_OFF_TOP_UPPER   8'h0c
`define RSP_OFF_PC_LOW      8'h10
`define RSP_OFF_LATCH_HIGH  8'h14
`define RSP_OFF_LATCH_UPPER 8'h18
`define RSP_OFF_CONFIG      8'h1c

// Field positions of the stack pointer status register
`define RSP_FULL_BIT        7
`define RSP_UNF_BIT         6
`define RSP_SP_MSB          4
`define RSP_SP_LSB          0
// Field position of the configuration register
`define RSP_FAULT_EN_BIT    0

// Reset values
`define RSP_SP_RST          5'h00
`define RSP_PC_RST          21'h000000
`define RSP_FAULT_EN_RST    1'h1

// Stack pointer landmarks and PC step
`define RSP_SP_TOP          5'h1f
`define RSP_SP_LAST_FREE    5'h1e
`define RSP_PC_STEP         21'h000002

`endif

// *** common/rsp_pkg.sv ***
// Types shared by the return stack and PC latch block
package rsp_pkg;

	typedef enum logic [3:0] {
		RSP_OP_NONE,
		RSP_OP_ADVANCE,
		RSP_OP_JUMP,
		RSP_OP_CALL,
		RSP_OP_CALL_FAST,
		RSP_OP_INT_VEC,
		RSP_OP_PUSH,
		RSP_OP_POP,
		RSP_OP_RETURN,
		RSP_OP_RETURN_FAST
	} rsp_op_e;

	typedef logic [20:0] rsp_addr_t;

	typedef struct packed {
		rsp_op_e   op;
		rsp_addr_t target;
		logic [7:0] status;
		logic [7:0] working_register;
		logic [7:0] bank_select_register;
	} rsp_core_s;

	typedef struct packed {
		logic       valid;
		logic [7:0] status;
		logic [7:0] working_register;
		logic [7:0] bank_select_register;
	} rsp_restore_s;

	typedef struct packed {
		logic [31:0][20:0] mem;
		logic [4:0]        sp;
		logic              full;
		logic              unf;
		logic              fault_en;
		rsp_addr_t         pc;
		logic [7:0]        lath;
		logic [4:0]        latu;
		logic [7:0]        sh_status;
		logic [7:0]        sh_working_register;
		logic [7:0]        sh_bsr;
		rsp_restore_s      restore;
		logic              dev_rst;
		logic              ack;
		logic [31:0]       dat;
	} rsp_state_s;

endpackage

// *** test/rsp_core_model.sv ***
// Core sequencing model that issues one operation per request
module rsp_core_model (
	input  wire logic          clk_i,
	output rsp_pkg::rsp_core_s core_o
);
	timeunit 1ns;
	timeprecision 1ps;
	import rsp_pkg::*;

	initial core_o = '0;

	// Op stands one cycle; idle fields then change so nothing stale is kept
	task automatic issue(input rsp_op_e op, input rsp_addr_t t = '0,
		input logic [23:0] r = '0);
		@(posedge clk_i);
		core_o <= {op, t, r};
		@(posedge clk_i);
		core_o <= {RSP_OP_NONE, ~t, ~r};
	endtask
endmodule

// *** test/tb.sv ***
// Self-checking bench for the return stack and PC latch block
`include "rsp_cfg.svh"
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import rsp_pkg::*;
	localparam logic [7:0] A_SP  = `RSP_OFF_SP_STATUS;
	localparam logic [7:0] A_TL  = `RSP_OFF_TOP_LOW;
	localparam logic [7:0] A_TH  = `RSP_OFF_TOP_HIGH;
	localparam logic [7:0] A_PCL = `RSP_OFF_PC_LOW;
	localparam logic [7:0] A_LH  = `RSP_OFF_LATCH_HIGH;
	localparam logic [7:0] A_LU  = `RSP_OFF_LATCH_UPPER;
	localparam logic [7:0] A_CFG = `RSP_OFF_CONFIG;
	logic         clk_i;
	logic         rst_i;
	logic         dev_rst_i;
	logic         cyc;
	logic         stb;
	logic         we;
	logic [7:0]   adr;
	logic [31:0]  wdat;
	logic [31:0]  q;
	logic         ack_o;
	logic [31:0]  dat_o;
	logic         dev_reset_o;
	rsp_core_s    core;
	rsp_addr_t    pc_o;
	rsp_restore_s restore_o;
	rsp_restore_s rest;
	int           num_errors;
	int           samples_checked;
	int           resets_seen;
	int           restores_seen;
	int           n0;

	rsp_stack u_dut (.clk_i(clk_i), .rst_i(rst_i), .dev_rst_i(dev_rst_i),
		.core_i(core), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
		.sel_i(4'h1), .dat_i(wdat), .ack_o(ack_o), .dat_o(dat_o),
		.pc_o(pc_o), .restore_o(restore_o), .dev_reset_o(dev_reset_o));
	rsp_core_model u_core (.clk_i(clk_i), .core_o(core));

	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	// Pulse monitors for the fault reset request and shadow restore
	always @(posedge clk_i) begin
		if (dev_reset_o === 1'b1) resets_seen++;
		if (restore_o.valid === 1'b1) begin
			restores_seen++;
			rest = restore_o;
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(negedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 20);
		if (ack_o !== 1'b1) num_errors++;
		q = dat_o;
		@(posedge clk_i);
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wb(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		chk(q, e);
	endtask

	task automatic cpc(input rsp_addr_t e);
		@(negedge clk_i);
		chk({11'h0, pc_o}, {11'h0, e});
	endtask

	task automatic t_reset;
		rd(A_SP, 32'h0);
		rd(A_CFG, 32'h1);
		cpc(21'h0);
		rd(8'h20, 32'h0);
	endtask

	task automatic t_calls;
		u_core.issue(RSP_OP_ADVANCE);
		u_core.issue(RSP_OP_ADVANCE);
		cpc(21'h4);
		u_core.issue(RSP_OP_CALL, 21'h1abcd);
		cpc(21'h1abcc);
		rd(A_SP, 32'h1);
		rd(A_TL, 32'h4);
		rd(A_LH, 32'h0);
		u_core.issue(RSP_OP_PUSH);
		rd(A_SP, 32'h2);
		rd(A_TL, 32'hcc);
		rd(A_TH, 32'hab);
		rd(A_TL + 8'h08, 32'h01);
		u_core.issue(RSP_OP_POP);
		rd(A_SP, 32'h1);
		wr(A_TH, 32'h22);
		u_core.issue(RSP_OP_RETURN);
		cpc(21'h02204);
		rd(A_SP, 32'h0);
	endtask

	task automatic t_shadow;
		u_core.issue(RSP_OP_INT_VEC, 21'h8, 24'h112233);
		u_core.issue(RSP_OP_INT_VEC, 21'h18, 24'h445566);
		n0 = restores_seen;
		u_core.issue(RSP_OP_RETURN_FAST);
		repeat (2) @(posedge clk_i);
		chk(32'(restores_seen), 32'(n0 + 1));
		chk({8'h0, rest.status, rest.working_register, rest.bank_select_register}, 32'h445566);
		u_core.issue(RSP_OP_RETURN);
		repeat (2) @(posedge clk_i);
		chk(32'(restores_seen), 32'(n0 + 1));
		u_core.issue(RSP_OP_CALL_FAST, 21'h100, 24'h778899);
		u_core.issue(RSP_OP_RETURN_FAST);
		repeat (2) @(posedge clk_i);
		chk({8'h0, rest.status, rest.working_register, rest.bank_select_register}, 32'h778899);
		rd(A_SP, 32'h0);
	endtask

	task automatic t_pclatch;
		u_core.issue(RSP_OP_JUMP, 21'h12345);
		rd(A_PCL, 32'h44);
		rd(A_LH, 32'h23);
		rd(A_LU, 32'h01);
		wr(A_LH, 32'hab);
		wr(A_LU, 32'h1c);
		wr(A_PCL, 32'h57);
		cpc(21'h1cab56);
		u_core.issue(RSP_OP_ADVANCE);
		cpc(21'h1cab58);
	endtask

	task automatic t_faults;
		wr(A_CFG, 32'h0);
		n0 = resets_seen;
		u_core.issue(RSP_OP_RETURN);
		cpc(21'h0);
		rd(A_SP, 32'h40);
		chk(32'(resets_seen), 32'(n0));
		wr(A_SP, 32'h25);
		rd(A_SP, 32'h05);
		wr(A_SP, 32'h1d);
		u_core.issue(RSP_OP_JUMP, 21'h120);
		u_core.issue(RSP_OP_PUSH);
		u_core.issue(RSP_OP_PUSH);
		rd(A_SP, 32'h9f);
		u_core.issue(RSP_OP_JUMP, 21'h342);
		u_core.issue(RSP_OP_PUSH);
		rd(A_TL, 32'h20);
		rd(A_SP, 32'h9f);
		@(posedge clk_i);
		dev_rst_i <= 1'b1;
		@(posedge clk_i);
		dev_rst_i <= 1'b0;
		rd(A_SP, 32'h80);
		wr(A_CFG, 32'h1);
		wr(A_SP, 32'h1e);
		u_core.issue(RSP_OP_JUMP, 21'h456);
		n0 = resets_seen;
		u_core.issue(RSP_OP_PUSH);
		rd(A_SP, 32'h80);
		chk(32'(resets_seen), 32'(n0 + 1));
		wr(A_SP, 32'h1f);
		rd(A_TL, 32'h58);
		wr(A_SP, 32'h0);
		u_core.issue(RSP_OP_POP);
		rd(A_SP, 32'h40);
		chk(32'(resets_seen), 32'(n0 + 2));
		fork
			wr(A_SP, 32'h07);
			begin
				@(posedge clk_i);
				u_core.issue(RSP_OP_PUSH);
			end
		join
		rd(A_SP, 32'h07);
	endtask

	task automatic final_report;
		$display("errors %0d checks %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	initial begin
		rst_i = 1'b1;
		dev_rst_i = 1'b0;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		wdat = 32'h0;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_calls();
		t_shadow();
		t_pclatch();
		t_faults();
		final_report();
	end

	initial begin
		repeat (5000) @(posedge clk_i);
		num_errors++;
		final_report();
	end
endmodule
